// *** core/scm_ctrl.sv ***
// system clock mode controller: prescaler, divider, mode sequencer, registers
// assumes: fast/slow oscillator outputs arrive as pins slower than sys_clk_i/2,
// cpu and interrupt signals come from logic on sys_clk_i
`timescale 1ns/1ps
`include "scm_cfg.svh"
module scm_ctrl
  import scm_pkg::*;
(
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_n_i,
  // oscillator and wake pins
  input  wire logic                  fast_clock_i,
  input  wire logic                  slow_clock_i,
  input  wire logic                  stop_wake_n_i,
  // register port
  input  wire logic [3:0]            reg_addr_i,
  input  wire logic [7:0]            reg_wdata_i,
  input  wire logic                  reg_we_i,
  input  wire logic                  reg_re_i,
  output logic [7:0]                 reg_rdata_o,
  // interrupt side
  input  wire logic                  irq_req_i,
  input  wire logic                  interrupt_master_enable_i,
  input  wire logic                  timebase_irq_individual_enable_i,
  output logic                       irq_service_o,
  output logic                       timebase_interrupt_o,
  // instruction sequencing
  input  wire logic                  insn_start_i,
  input  wire logic [3:0]            insn_cycles_i,
  output logic                       insn_done_o,
  // clocks and status
  output scm_mode_t                  mode_o,
  output logic [1:0]                 machine_state_o,
  output logic                       cpu_state_tick_o,
  output logic                       periph_tick_o,
  output logic                       watchdog_tick_o,
  output logic                       timebase_tick_o,
  output logic [`SCM_TAP_W-1:0]      divider_taps_o,
  output logic                       divider_output_pulse_o,
  output logic                       fast_osc_run_o,
  output logic                       slow_osc_run_o,
  output logic                       slow_osc_pins_port_o
);
  logic fc_s, fs_s, wake_s;
  logic fc_prev_q, fc_prev_d, fs_prev_q, fs_prev_d;
  logic fc_tick, fs_tick, main_tick, cycle_end;
  logic [1:0] mstate;
  logic [1:0] pre_q, pre_d;
  logic [`SCM_LO_W-1:0] lo_q, lo_d;
  logic [`SCM_HI_W-1:0] hi_q, hi_d;
  logic [`SCM_TAP_W-1:0] taps;
  logic pre_carry, lo_carry, st7_tick, low_run, div_clr;
  logic [7:0] c1_q, c1_d, c2_q, c2_d, tb_q, tb_d, rd_q, rd_d;
  scm_mode_t mode_q, mode_d, ret_q, ret_d;
  logic tben_q, tben_d, dwake_q, dwake_d, tbirq_q, tbirq_d, svc_q, svc_d;
  logic tb_prev_q, tb_prev_d, tb_src, tb_fall;
  logic [3:0] icnt_q, icnt_d;
  logic done_q, done_d;
  logic slow_main, cpu_run, periph_run, halt_wake, stop_enter, stop_leave;
  logic dual, warm_done;

  // pin levels: two flops before any logic
  scm_sync #(.RST_VAL(1'b0)) u_sync_fc (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (fast_clock_i),
    .sync_o    (fc_s)
  );
  scm_sync #(.RST_VAL(1'b0)) u_sync_fs (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (slow_clock_i),
    .sync_o    (fs_s)
  );
  scm_sync #(.RST_VAL(1'b1)) u_sync_wake (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (stop_wake_n_i),
    .sync_o    (wake_s)
  );

  // oscillator edges; a stopped oscillator gives no ticks
  always_comb begin
    fc_prev_d = fc_s;
    fs_prev_d = fs_s;
  end
  assign fc_tick = fc_s & ~fc_prev_q & fast_osc_run_o;
  assign fs_tick = fs_s & ~fs_prev_q & slow_osc_run_o;

  // mode groups
  assign dual       = c2_q[`SCM_C2_SLOW_EN];
  assign slow_main  = mode_q inside {SCM_SRB, SCM_SRL, SCM_SLH};
  assign cpu_run    = mode_q inside {SCM_FRS, SCM_FRD, SCM_SRB, SCM_SRL};
  assign periph_run = !(mode_q inside {SCM_DFH, SCM_STP, SCM_WRM});
  assign low_run    = !(mode_q inside {SCM_SRL, SCM_SLH, SCM_STP});
  assign main_tick  = slow_main ? fs_tick : (mode_q inside {SCM_STP, SCM_WRM}) ? 1'b0 : fc_tick;

  // prescaler and divider chain
  assign pre_carry = fc_tick & low_run & (pre_q == `SCM_PRE_LAST);
  assign lo_carry  = pre_carry & (&lo_q);
  always_comb begin
    // stage-7 source; switching here never truncates a stage count
    if (slow_main || (mode_q == SCM_WRM && ret_q inside {SCM_SRB, SCM_SRL})) begin
      st7_tick = fs_tick;
    end else if (mode_q == SCM_WRM) begin
      st7_tick = lo_carry;
    end else if (mode_q == SCM_STP) begin
      st7_tick = 1'b0;
    end else if (tb_q[`SCM_TB_DV7]) begin
      st7_tick = fs_tick;
    end else begin
      st7_tick = lo_carry;
    end
  end
  always_comb begin
    pre_d = pre_q;
    lo_d  = lo_q;
    hi_d  = hi_q;
    if (div_clr) begin
      pre_d = 2'h0;
      lo_d  = '0;
      hi_d  = '0;
    end else begin
      if (fc_tick && low_run) begin
        pre_d = pre_q + 2'h1;
      end
      if (pre_carry) begin
        lo_d = lo_q + 6'h01;
      end
      if (st7_tick) begin
        hi_d = hi_q + 15'h0001;
      end
    end
  end
  assign taps = {hi_q, lo_q};

  // time-base source and its falling edge
  always_comb begin
    unique case (tb_q[`SCM_TB_SEL_HI:`SCM_TB_SEL_LO])
      3'h0:    tb_src = taps[`SCM_TB_TAP0];
      3'h1:    tb_src = taps[`SCM_TB_TAP1];
      3'h2:    tb_src = taps[`SCM_TB_TAP2];
      3'h3:    tb_src = taps[`SCM_TB_TAP3];
      3'h4:    tb_src = taps[`SCM_TB_TAP4];
      3'h5:    tb_src = taps[`SCM_TB_TAP5];
      3'h6:    tb_src = taps[`SCM_TB_TAP6];
      default: tb_src = taps[`SCM_TB_TAP7];
    endcase
    tb_prev_d = tb_src;
  end
  assign tb_fall = tb_prev_q & ~tb_src;

  // machine-cycle counter on the main clock
  scm_mcycle u_mcycle (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .tick_i      (main_tick),
    .clr_i       (div_clr),
    .state_o     (mstate),
    .cycle_end_o (cycle_end)
  );

  // wake and stop events
  assign halt_wake  = irq_req_i & (mode_q inside {SCM_FHS, SCM_FHD, SCM_SLH});
  assign stop_enter = cycle_end & cpu_run & c1_q[`SCM_C1_STOP];
  assign stop_leave = (mode_q == SCM_STP) & ~wake_s;
  assign warm_done  = (mode_q == SCM_WRM) & taps[`SCM_WARM_TAP];
  assign div_clr    = stop_enter | stop_leave;

  // mode sequencer: run and halt changes only at a cycle boundary
  always_comb begin
    mode_d  = mode_q;
    ret_d   = ret_q;
    tben_d  = tben_q;
    dwake_d = dwake_q | ((mode_q == SCM_DFH) & tb_fall);
    tbirq_d = 1'b0;
    svc_d   = 1'b0;
    if (stop_enter) begin
      mode_d = SCM_STP;
      ret_d  = mode_q;
    end else if (stop_leave) begin
      mode_d = SCM_WRM;
    end else if (warm_done) begin
      mode_d = ret_q;
    end else if (cycle_end) begin
      unique case (mode_q)
        SCM_FRS: begin
          if (c2_q[`SCM_C2_TIMING_GEN_HALT_BIT]) begin
            mode_d = SCM_DFH;
            tben_d = tb_q[`SCM_TB_EN];
            dwake_d = 1'b0;
          end else if (c2_q[`SCM_C2_HALT]) begin
            mode_d = SCM_FHS;
          end else if (dual) begin
            mode_d = SCM_FRD;
          end
        end
        SCM_FRD: begin
          if (c2_q[`SCM_C2_HALT]) begin
            mode_d = SCM_FHD;
          end else if (!dual) begin
            mode_d = SCM_FRS;
          end else if (c2_q[`SCM_C2_MAIN_SEL]) begin
            mode_d = SCM_SRB;
          end
        end
        SCM_SRB: begin
          if (c2_q[`SCM_C2_HALT]) begin
            mode_d = SCM_SLH;
          end else if (!c2_q[`SCM_C2_MAIN_SEL]) begin
            mode_d = SCM_FRD;
          end else if (!c2_q[`SCM_C2_FAST_EN]) begin
            mode_d = SCM_SRL;
          end
        end
        SCM_SRL: begin
          if (c2_q[`SCM_C2_HALT]) begin
            mode_d = SCM_SLH;
          end else if (c2_q[`SCM_C2_FAST_EN]) begin
            mode_d = SCM_SRB;
          end
        end
        SCM_FHS, SCM_FHD, SCM_SLH: begin
          if (halt_wake) begin
            mode_d = (mode_q == SCM_FHS) ? SCM_FRS : (mode_q == SCM_FHD) ? SCM_FRD
                   : c2_q[`SCM_C2_FAST_EN] ? SCM_SRB : SCM_SRL;
            svc_d  = interrupt_master_enable_i;
          end
        end
        SCM_DFH: begin
          if (dwake_q) begin
            mode_d  = SCM_FRS;
            tbirq_d = tben_q;
            svc_d   = tben_q & interrupt_master_enable_i & timebase_irq_individual_enable_i;
          end
        end
        default: mode_d = SCM_FRS;
      endcase
    end
  end

  // instruction length counter in machine cycles
  always_comb begin
    icnt_d = icnt_q;
    done_d = 1'b0;
    if (insn_start_i) begin
      icnt_d = (insn_cycles_i == 4'h0) ? `SCM_ONE_CYC
             : (insn_cycles_i > `SCM_MAX_CYC) ? `SCM_MAX_CYC : insn_cycles_i;
    end else if (cycle_end && cpu_run && icnt_q != 4'h0) begin
      icnt_d = icnt_q - 4'h1;
      done_d = (icnt_q == `SCM_ONE_CYC);
    end
  end

  // register port; hardware clears halt requests on wake and the stop request when warm-up ends
  always_comb begin
    c1_d = c1_q;
    c2_d = c2_q;
    tb_d = tb_q;
    rd_d = `SCM_ZERO8;
    if (warm_done) begin
      c1_d[`SCM_C1_STOP] = 1'b0;
    end
    if (mode_d != mode_q && (mode_q inside {SCM_FHS, SCM_FHD, SCM_SLH})) begin
      c2_d[`SCM_C2_HALT] = 1'b0;
    end
    if (mode_d != mode_q && mode_q == SCM_DFH) begin
      c2_d[`SCM_C2_TIMING_GEN_HALT_BIT] = 1'b0;
    end
    if (reg_we_i) begin
      unique case (reg_addr_i)
        `SCM_ADDR_CTRL1: c1_d = reg_wdata_i & 8'h80;
        `SCM_ADDR_CTRL2: c2_d = reg_wdata_i & 8'hec;
        `SCM_ADDR_TBC:   tb_d = reg_wdata_i & 8'h1f;
        default:         ;
      endcase
    end
    if (reg_re_i) begin
      unique case (reg_addr_i)
        `SCM_ADDR_CTRL1: rd_d = c1_q;
        `SCM_ADDR_CTRL2: rd_d = c2_q;
        `SCM_ADDR_TBC:   rd_d = tb_q;
        `SCM_ADDR_STAT:  rd_d = {cpu_run, dual, fast_osc_run_o, slow_osc_run_o,
                                 ~periph_run, slow_main, mstate};
        default:         rd_d = `SCM_ZERO8;
      endcase
    end
  end

  // all state registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      fc_prev_q <= 1'b0;
      fs_prev_q <= 1'b0;
      pre_q     <= 2'h0;
      lo_q      <= '0;
      hi_q      <= '0;
      tb_prev_q <= 1'b0;
      mode_q    <= SCM_FRS;
      ret_q     <= SCM_FRS;
      tben_q    <= 1'b0;
      dwake_q   <= 1'b0;
      tbirq_q   <= 1'b0;
      svc_q     <= 1'b0;
      icnt_q    <= 4'h0;
      done_q    <= 1'b0;
      c1_q      <= `SCM_C1_RST;
      c2_q      <= `SCM_C2_RST;
      tb_q      <= `SCM_TB_RST;
      rd_q      <= `SCM_ZERO8;
    end else begin
      fc_prev_q <= fc_prev_d;
      fs_prev_q <= fs_prev_d;
      pre_q     <= pre_d;
      lo_q      <= lo_d;
      hi_q      <= hi_d;
      tb_prev_q <= tb_prev_d;
      mode_q    <= mode_d;
      ret_q     <= ret_d;
      tben_q    <= tben_d;
      dwake_q   <= dwake_d;
      tbirq_q   <= tbirq_d;
      svc_q     <= svc_d;
      icnt_q    <= icnt_d;
      done_q    <= done_d;
      c1_q      <= c1_d;
      c2_q      <= c2_d;
      tb_q      <= tb_d;
      rd_q      <= rd_d;
    end
  end

  // outputs; the slow oscillator stays off in single mode
  assign reg_rdata_o            = rd_q;
  assign irq_service_o          = svc_q;
  assign timebase_interrupt_o   = tbirq_q;
  assign insn_done_o            = done_q;
  assign mode_o                 = mode_q;
  assign machine_state_o        = mstate;
  assign cpu_state_tick_o       = main_tick & cpu_run;
  assign periph_tick_o          = main_tick & periph_run;
  assign watchdog_tick_o        = main_tick & cpu_run;
  assign timebase_tick_o        = tb_fall;
  assign divider_taps_o         = taps;
  assign divider_output_pulse_o = taps[`SCM_DVO_TAP];
  assign fast_osc_run_o         = !(mode_q inside {SCM_STP, SCM_SRL, SCM_SLH});
  assign slow_osc_run_o         = dual & (mode_q != SCM_STP);
  assign slow_osc_pins_port_o   = ~dual;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_slow_tick;
    slow_main && fs_tick && !div_clr;
  endsequence
  a_div_clear_stop: assert property (div_clr |=> (pre_q == 2'h0 && taps == '0))
    else $error("divider not cleared on stop entry or exit");
  a_slow_stage7: assert property (s_slow_tick |=> hi_q == $past(hi_q) + 15'h0001)
    else $error("fs did not feed stage 7 in slow mode");
  a_warm_stage7: assert property ((mode_q == SCM_WRM && ret_q == SCM_FRD && tb_q[`SCM_TB_DV7]
      && fs_tick && !lo_carry && !warm_done) |=> hi_q == $past(hi_q))
    else $error("stage 7 select honoured during warm-up");
  a_low_div_stop: assert property ((mode_q == SCM_SRL && !div_clr) |=> lo_q == $past(lo_q))
    else $error("low divider stages ran in slow low mode");
  a_switch_bound: assert property ((mode_q != $past(mode_q) && !$past(div_clr)
      && !$past(warm_done)) |-> $past(cycle_end))
    else $error("mode changed away from a cycle boundary");
  a_halt_wake: assert property ((mode_q == SCM_FHS && irq_req_i && cycle_end)
      |=> (mode_q == SCM_FRS && svc_q == $past(interrupt_master_enable_i)))
    else $error("fast halt not ended by interrupt");
  a_deep_wake: assert property ((mode_q == SCM_DFH && dwake_q && cycle_end)
      |=> (mode_q == SCM_FRS && tbirq_q == $past(tben_q)))
    else $error("deep halt not ended on time-base edge");
  a_insn_bound: assert property ((icnt_q <= `SCM_MAX_CYC) && !(done_q && !$past(cycle_end)))
    else $error("instruction length out of range");
  a_deep_gate: assert property ((mode_q == SCM_DFH) |-> !periph_tick_o && !cpu_state_tick_o)
    else $error("clocks not gated in deep halt");
endmodule : scm_ctrl

// *** core/scm_cfg.svh ***
// named constants of the system clock mode controller
// assumes: 8-bit register port, one 10 MHz system clock, sampled fc/fs pins
// How it works
// - clocks come from a 2-stage prescaler, 21-stage divider and machine-cycle counter
// - reset and stop entry or exit clear prescaler and divider to zero
// - stage-7 input chosen by mode, main clock select and stage-7 select bit
// - in slow run or slow halt, fs feeds stage 7 directly
// - warm-up after stop entered from fast run feeds stage 6 into stage 7
// - a machine cycle is four states, each one main clock period
// - instructions run whole machine cycles, one to ten of them
// - single mode runs fc only, slow pins are ports, cycle 4/fc
// - reset enters single-clock fast run
// - halt bit enters fast halt; cpu and watchdog stop, peripherals run
// - any interrupt ends fast halt; master enable decides service or resume
// - timing generator halt bit in single mode enters deep fast halt
// - time-base source falling edge ends deep halt into single fast run
// - deep halt ignores timebase enable; latch set on return if enabled
// - dual mode runs both oscillators, fs only in slow low and slow halt; main clock fc or fs by mode
// - dual fast run clocks cpu from fc, peripherals from fc or fs
// - main clock select one goes slow, zero returns to dual fast run
// - clearing fast oscillator enable in slow both moves to slow low
// - generator supplies main clock, divider pulses and source clocks
// - slow low run and its halt stop divider stages one to six
`ifndef SCM_CFG_SVH
`define SCM_CFG_SVH
// register offsets
`define SCM_ADDR_CTRL1      4'h0
`define SCM_ADDR_CTRL2      4'h1
`define SCM_ADDR_TBC        4'h2
`define SCM_ADDR_STAT       4'h3
// field positions
`define SCM_C1_STOP         7
`define SCM_C2_FAST_EN      7
`define SCM_C2_SLOW_EN      6
`define SCM_C2_MAIN_SEL     5
`define SCM_C2_HALT         3
`define SCM_C2_TIMING_GEN_HALT_BIT       2
`define SCM_TB_DV7          4
`define SCM_TB_EN           3
`define SCM_TB_SEL_HI       2
`define SCM_TB_SEL_LO       0
// reset values
`define SCM_C1_RST          8'h00
`define SCM_C2_RST          8'h80
`define SCM_TB_RST          8'h00
`define SCM_ZERO8           8'h00
// divider geometry and taps
`define SCM_PRE_LAST        2'h3
`define SCM_LO_W            6
`define SCM_HI_W            15
`define SCM_TAP_W           21
`define SCM_DVO_TAP         12
`define SCM_WARM_TAP        15
`define SCM_TB_TAP0         20
`define SCM_TB_TAP1         18
`define SCM_TB_TAP2         13
`define SCM_TB_TAP3         11
`define SCM_TB_TAP4         10
`define SCM_TB_TAP5         9
`define SCM_TB_TAP6         7
`define SCM_TB_TAP7         5
// machine cycle
`define SCM_LAST_STATE      2'h3
`define SCM_MAX_CYC         4'ha
`define SCM_ONE_CYC         4'h1
`endif

// *** core/scm_pkg.sv ***
// types of the system clock mode controller
// assumes: scm_cfg.svh supplies the numeric constants
package scm_pkg;
  // operating modes, one-hot
  typedef enum logic [9:0] {
    SCM_FRS = 10'h001, // fast_run_single_mode
    SCM_FHS = 10'h002, // fast_halt_single_mode
    SCM_DFH = 10'h004, // deep_fast_halt_mode
    SCM_FRD = 10'h008, // fast_run_dual_mode
    SCM_FHD = 10'h010, // fast_halt_dual_mode
    SCM_SRB = 10'h020, // slow_run_both_osc_mode
    SCM_SRL = 10'h040, // slow_run_low_osc_mode
    SCM_SLH = 10'h080, // halt on the slow clock
    SCM_STP = 10'h100, // oscillators off
    SCM_WRM = 10'h200  // warm-up after stop
  } scm_mode_t;
endpackage : scm_pkg

// *** core/scm_sync.sv ***
// two-flop synchroniser for one pin level
// assumes: input is asynchronous to sys_clk_i
`timescale 1ns/1ps
module scm_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // level in and out
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_q, meta_d, sync_q, sync_d;

  // first flop feeds only the second
  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule : scm_sync

// *** core/scm_mcycle.sv ***
// machine-cycle state counter S0..S3
// assumes: tick_i is one main clock period pulse from the same clock
`timescale 1ns/1ps
`include "scm_cfg.svh"
module scm_mcycle (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // main clock tick and clear
  input  wire logic       tick_i,
  input  wire logic       clr_i,
  // state and boundary
  output logic [1:0]      state_o,
  output logic            cycle_end_o
);
  logic [1:0] state_q, state_d;

  // one state per main clock period
  always_comb begin
    state_d = state_q;
    if (clr_i) begin
      state_d = 2'h0;
    end else if (tick_i) begin
      state_d = state_q + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_q <= 2'h0;
    end else begin
      state_q <= state_d;
    end
  end

  assign state_o     = state_q;
  assign cycle_end_o = tick_i & (state_q == `SCM_LAST_STATE);

  a_state_wrap: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (tick_i && !clr_i && state_q == `SCM_LAST_STATE) |=> (state_q == 2'h0))
    else $error("machine cycle did not wrap after S3");
  a_state_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!tick_i && !clr_i) |=> (state_q == $past(state_q)))
    else $error("state moved without a main clock tick");
endmodule : scm_mcycle

// *** test/scm_osc_model.sv ***
// oscillator pair model for the clock controller bench
// assumes: run levels come from the controller on sys_clk_i
`timescale 1ns/1ps
module scm_osc_model (
  // clock
  input  wire logic sys_clk_i,
  // run requests
  input  wire logic fast_run_i,
  input  wire logic slow_run_i,
  // oscillator pins
  output logic      fast_clock_o,
  output logic      slow_clock_o
);
  int fcnt = 0;
  int scnt = 0;
  // a stopped oscillator holds its pin still, no stray edges
  initial begin
    fast_clock_o = 1'b0;
    slow_clock_o = 1'b0;
  end
  // fast pin period 4 cycles, slow pin 14, both under sys_clk/2
  always @(posedge sys_clk_i) begin
    if (fast_run_i) begin
      fcnt = (fcnt + 1) % 2;
      if (fcnt == 0) fast_clock_o <= ~fast_clock_o;
    end
    if (slow_run_i) begin
      scnt = (scnt + 1) % 7;
      if (scnt == 0) slow_clock_o <= ~slow_clock_o;
    end
  end
endmodule : scm_osc_model

// *** test/scm_ctrl_tb.sv ***
// self-checking bench for the clock mode controller
// assumes: 10 MHz sys clock, oscillator pins from scm_osc_model
`timescale 1ns/1ps
`include "scm_cfg.svh"
module scm_ctrl_tb
  import scm_pkg::*;
;
  logic        sys_clk_i, rst_n_i, fclk, sclk, wake_n, we, re, irq, interrupt_master_enable, ef6, istart;
  logic        svc, tbi, idone, cpu_t, per_t, fast_run, slow_run, port_o, wd_t, time_base_timer, divider_output_pulse;
  logic [3:0]  addr, icyc;
  logic [7:0]  wdata, rdata, v, rv;
  logic [1:0]  mst, mst_q;
  logic [20:0] taps;
  logic [5:0]  lo;
  scm_mode_t   mode;
  int          n_errors, tests_run, seed, n_svc, n_tbi, n_wrap, n_ct, k, nc, np, nw, nd, n_tbt;

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  scm_osc_model osc (.sys_clk_i(sys_clk_i), .fast_run_i(fast_run), .slow_run_i(slow_run),
    .fast_clock_o(fclk), .slow_clock_o(sclk));

  scm_ctrl dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .fast_clock_i(fclk),
    .slow_clock_i(sclk), .stop_wake_n_i(wake_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .irq_req_i(irq),
    .interrupt_master_enable_i(interrupt_master_enable), .timebase_irq_individual_enable_i(ef6),
    .irq_service_o(svc), .timebase_interrupt_o(tbi), .insn_start_i(istart),
    .insn_cycles_i(icyc), .insn_done_o(idone), .mode_o(mode), .machine_state_o(mst),
    .cpu_state_tick_o(cpu_t), .periph_tick_o(per_t), .watchdog_tick_o(wd_t),
    .timebase_tick_o(time_base_timer), .divider_taps_o(taps), .divider_output_pulse_o(divider_output_pulse),
    .fast_osc_run_o(fast_run), .slow_osc_run_o(slow_run), .slow_osc_pins_port_o(port_o));

  // pulse and boundary counters, since pulses stand one cycle only
  always @(posedge sys_clk_i) begin
    mst_q <= mst;
    if (svc === 1'b1) n_svc++;
    if (tbi === 1'b1) n_tbi++;
    if (cpu_t === 1'b1) n_ct++;
    if (time_base_timer === 1'b1) n_tbt++;
    if (divider_output_pulse !== taps[`SCM_DVO_TAP]) nd++;
    if (mst_q === 2'h3 && mst === 2'h0) n_wrap++;
  end

  task automatic chk_val(input string nm, input logic [20:0] e, input logic [20:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  task automatic chk_mode(input scm_mode_t e, input scm_mode_t g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch mode expected %h seen %h", e, g);
    end
  endtask : chk_mode

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // register port: one-cycle strobes launched just after a rising edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge sys_clk_i);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge sys_clk_i);
    re <= 1'b0;
    @(negedge sys_clk_i);
    d = rdata;
  endtask : rd

  task automatic wait_mode(input scm_mode_t m, input int lim);
    k = 0;
    while (mode !== m && k < lim) begin
      @(negedge sys_clk_i);
      k++;
    end
    chk_mode(m, mode);
  endtask : wait_mode

  task automatic count_ticks(input int cyc);
    nc = 0;
    np = 0;
    nw = 0;
    repeat (cyc) begin
      @(negedge sys_clk_i);
      if (cpu_t === 1'b1) nc++;
      if (wd_t === 1'b1) nw++;
      if (per_t === 1'b1) np++;
    end
  endtask : count_ticks

  task automatic do_reset;
    rst_n_i <= 1'b0;
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(negedge sys_clk_i);
  endtask : do_reset

  // start at the first cycle of a machine cycle, count boundaries to done
  task automatic run_insn(input int len);
    k = 0;
    while (!(mst_q === 2'h3 && mst === 2'h0) && k < 400) begin
      @(negedge sys_clk_i);
      k++;
    end
    @(posedge sys_clk_i);
    icyc <= 4'(len);
    istart <= 1'b1;
    @(negedge sys_clk_i);
    n_wrap = 0;
    n_ct = 0;
    @(posedge sys_clk_i);
    istart <= 1'b0;
    k = 0;
    while (idone !== 1'b1 && k < 3000) begin
      @(negedge sys_clk_i);
      k++;
    end
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk_val("machine cycles", 21'(len), 21'(n_wrap));
    chk_val("states", 21'(4 * len), 21'(n_ct));
  endtask : run_insn

  initial begin
    seed = 27;
    {n_errors, tests_run, n_svc, n_tbi, n_wrap, n_ct, n_tbt, nd} = '0;
    {rst_n_i, addr, wdata, we, re, irq, istart} = '0;
    {interrupt_master_enable, ef6, wake_n, icyc} = {3'h7, 4'h1};
    do_reset();
    chk_mode(SCM_FRS, mode);
    chk_val("pins port", 21'h1, 21'(port_o));
    chk_val("slow osc", 21'h0, 21'(slow_run));
    rd(`SCM_ADDR_CTRL2, rv);
    chk_val("ctrl2", 21'(`SCM_C2_RST), 21'(rv));
    // random timebase settings; stage-7 select kept clear in single mode
    repeat (8) begin
      v = 8'($random(seed)) & 8'hef;
      wr(`SCM_ADDR_TBC, v);
      rd(`SCM_ADDR_TBC, rv);
      chk_val("tbc", 21'(v & 8'h1f), 21'(rv));
      rd(4'($random(seed)) | 4'h4, rv);
      chk_val("unmapped", 21'h0, 21'(rv));
    end
    run_insn(1);
    run_insn(10);
    repeat (4) run_insn(1 + (($random(seed) & 32'hff) % 10));
    // fast halt, woken by an interrupt with and without master enable
    for (int m = 1; m >= 0; m--) begin
      @(posedge sys_clk_i);
      interrupt_master_enable <= 1'(m);
      wr(`SCM_ADDR_CTRL2, 8'h88);
      wait_mode(SCM_FHS, 400);
      count_ticks(40);
      chk_val("halt cpu", 21'h0, 21'(nc));
      chk_val("halt wdt", 21'h0, 21'(nw));
      chk_val("halt periph", 21'h1, 21'(np > 0));
      n_svc = 0;
      @(posedge sys_clk_i);
      irq <= 1'b1;
      wait_mode(SCM_FRS, 400);
      @(posedge sys_clk_i);
      irq <= 1'b0;
      @(negedge sys_clk_i);
      chk_val("service", 21'(m), 21'(n_svc));
      rd(`SCM_ADDR_CTRL2, rv);
      chk_val("halt bit", 21'h80, 21'(rv));
    end
    // deep halt with the shortest time-base tap, enables all set
    @(posedge sys_clk_i);
    interrupt_master_enable <= 1'b1;
    wr(`SCM_ADDR_TBC, 8'h0f);
    {n_tbi, n_tbt} = '0;
    n_svc = 0;
    wr(`SCM_ADDR_CTRL2, 8'h84);
    wait_mode(SCM_DFH, 400);
    count_ticks(8);
    chk_val("deep periph", 21'h0, 21'(np));
    wait_mode(SCM_FRS, 4000);
    repeat (3) @(posedge sys_clk_i);
    chk_val("tb latch", 21'h1, 21'(n_tbi));
    chk_val("tb service", 21'h1, 21'(n_svc));
    chk_val("tb edge", 21'h1, 21'(n_tbt > 0));
    // dual clock walk; slow oscillator enabled first and never cleared in slow
    wr(`SCM_ADDR_CTRL2, 8'hc0);
    wait_mode(SCM_FRD, 400);
    chk_val("dual pins", 21'h0, 21'(port_o));
    wr(`SCM_ADDR_CTRL2, 8'he0);
    wait_mode(SCM_SRB, 400);
    wr(`SCM_ADDR_CTRL2, 8'h60);
    wait_mode(SCM_SRL, 400);
    @(negedge sys_clk_i);
    lo = taps[5:0];
    count_ticks(60);
    chk_val("low stages", 21'(lo), 21'(taps[5:0]));
    wr(`SCM_ADDR_CTRL2, 8'he0);
    wait_mode(SCM_SRB, 400);
    wr(`SCM_ADDR_CTRL2, 8'hc0);
    wait_mode(SCM_FRD, 400);
    wr(`SCM_ADDR_TBC, 8'h10);
    // stop from dual fast run with fs on stage 7; warm-up too long, so reset
    wr(`SCM_ADDR_CTRL1, 8'h80);
    wait_mode(SCM_STP, 400);
    chk_val("stop taps", 21'h0, taps);
    chk_val("stop fast osc", 21'h0, 21'(fast_run));
    @(posedge sys_clk_i);
    wake_n <= 1'b0;
    wait_mode(SCM_WRM, 40);
    @(posedge sys_clk_i);
    wake_n <= 1'b1;
    count_ticks(40);
    chk_val("warm stage7", 21'h0, 21'(taps[20:6]));
    @(posedge sys_clk_i);
    do_reset();
    chk_mode(SCM_FRS, mode);
    chk_val("reset taps", 21'h0, taps);
    wr(`SCM_ADDR_CTRL2, 8'hc0);
    wait_mode(SCM_FRD, 400);
    wr(`SCM_ADDR_CTRL2, 8'h80);
    wait_mode(SCM_FRS, 400);
    chk_val("dvo", 21'h0, 21'(nd));
    report_and_stop();
  end

  // watchdog, well beyond the expected run length
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    n_errors++;
    report_and_stop();
  end
endmodule : scm_ctrl_tb
